/* File: verilog/ted_timer.sv */
`timescale 1ns/100ps
module ted_timer import ted_pkg::*; #(
	parameter int CNT_W = 16,
	parameter bit DIV_CAPABLE = 1'b1
)(
	input wire logic sys_clk_in, // operating clock, 125 MHz
	input wire logic rst_in, // async reset, active high
	input wire logic ce_in, // clock enable, freezes all state
	input wire logic wb_cyc_in, // wishbone cycle
	input wire logic wb_stb_in, // wishbone strobe
	input wire logic wb_we_in, // wishbone write
	input wire logic [7:0] wb_adr_in, // byte address
	input wire logic [3:0] wb_sel_in, // byte lanes
	input wire logic [31:0] wb_dat_in, // write data
	output logic [31:0] wb_dat_out, // read data
	output logic wb_ack_out, // acknowledge
	input wire logic timer_input_pin_in, // external edge source
	output logic timer_output_pin_out, // timer output level
	output logic timer_output_oe_out, // high while timer owns pin
	output logic channel_interrupt_out // one cycle interrupt pulse
);

	////////////////////////////////////////////////////////////////////////
	// state
	logic ack_ff, nxt_ack;
	logic [31:0] rdata_ff, nxt_rdata;
	logic gate_ff, nxt_gate;
	logic div_mode_ff, nxt_div_mode;
	logic [1:0] edge_sel_ff, nxt_edge_sel;
	logic init_sel_ff, nxt_init_sel;
	logic filt_en_ff, nxt_filt_en;
	logic [CNT_W-1:0] reload_ff, nxt_reload;
	logic [CNT_W-1:0] cnt_ff, nxt_cnt;
	logic active_ff, nxt_active;
	ted_state_type state_ff, nxt_state;
	logic irq_ff, nxt_irq;
	logic out_val_ff, nxt_out_val;
	logic out_en_ff, nxt_out_en;
	logic out_mode_ff, nxt_out_mode;
	logic out_inv_ff, nxt_out_inv;
	logic pin_ff, nxt_pin;
	logic pin_oe_ff, nxt_pin_oe;

	logic bus_req, wr_go, reg_wr, start_wr, stop_wr, toggle;
	logic valid_edge, div_eff;

	function automatic logic hit(input logic [7:0] adr,
		input logic [7:0] ofs);
		hit = (adr[7:2] == ofs[7:2]);
	endfunction

	function automatic logic [CNT_W-1:0] merge_lanes(
		input logic [CNT_W-1:0] old, input logic [31:0] dat,
		input logic [3:0] sel);
		logic [31:0] wide;
		wide = 32'h0000_0000;
		wide[CNT_W-1:0] = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				wide[i*8 +: 8] = dat[i*8 +: 8];
			end
		end
		merge_lanes = wide[CNT_W-1:0];
	endfunction

	////////////////////////////////////////////////////////////////////////
	// input edge detection
	ted_edge_det u_edge (
		.sys_clk_in(sys_clk_in),
		.rst_in(rst_in),
		.ce_in(ce_in),
		.clear_in(~gate_ff),
		.filt_en_in(filt_en_ff),
		.edge_sel_in(edge_sel_ff),
		.pin_in(timer_input_pin_in),
		.edge_out(valid_edge)
	);

	////////////////////////////////////////////////////////////////////////
	// wishbone slave: ack one cycle after the request, then dropped
	assign bus_req = wb_cyc_in & wb_stb_in & ~ack_ff;
	assign wr_go = bus_req & wb_we_in;
	assign reg_wr = wr_go & gate_ff;
	assign start_wr = reg_wr & hit(wb_adr_in, TED_OFS_TRIG) & wb_sel_in[0]
		& wb_dat_in[TED_TRIG_START_BIT];
	assign stop_wr = reg_wr & hit(wb_adr_in, TED_OFS_TRIG) & wb_sel_in[0]
		& wb_dat_in[TED_TRIG_STOP_BIT];
	// divider only where the channel supports it
	assign div_eff = DIV_CAPABLE & div_mode_ff;

	always_comb begin
		nxt_ack = bus_req;
		nxt_rdata = rdata_ff;
		if (bus_req && !wb_we_in) begin
			nxt_rdata = 32'h0000_0000;
			if (hit(wb_adr_in, TED_OFS_GATE)) begin
				nxt_rdata[TED_GATE_BIT] = gate_ff;
			end else if (hit(wb_adr_in, TED_OFS_MODE)) begin
				nxt_rdata[TED_MODE_DIV_BIT] = div_mode_ff;
				nxt_rdata[TED_MODE_EDGE_LSB +: 2] = edge_sel_ff;
				nxt_rdata[TED_MODE_INIT_BIT] = init_sel_ff;
			end else if (hit(wb_adr_in, TED_OFS_RELOAD)) begin
				nxt_rdata[CNT_W-1:0] = reload_ff;
			end else if (hit(wb_adr_in, TED_OFS_COUNT)) begin
				nxt_rdata[CNT_W-1:0] = cnt_ff;
			end else if (hit(wb_adr_in, TED_OFS_STAT)) begin
				nxt_rdata[TED_STAT_ACTIVE_BIT] = active_ff;
			end else if (hit(wb_adr_in, TED_OFS_OUTCTL)) begin
				nxt_rdata[TED_OUT_VAL_BIT] = out_val_ff;
				nxt_rdata[TED_OUT_EN_BIT] = out_en_ff;
				nxt_rdata[TED_OUT_MODE_BIT] = out_mode_ff;
				nxt_rdata[TED_OUT_INV_BIT] = out_inv_ff;
			end else if (hit(wb_adr_in, TED_OFS_FILT)) begin
				nxt_rdata[TED_FILT_EN_BIT] = filt_en_ff;
			end
		end
	end

	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			ack_ff <= 1'b0;
			rdata_ff <= 32'h0000_0000;
		end else if (ce_in) begin
			ack_ff <= nxt_ack;
			rdata_ff <= nxt_rdata;
		end
	end

	assign wb_ack_out = ack_ff;
	assign wb_dat_out = rdata_ff;

	////////////////////////////////////////////////////////////////////////
	// channel
	always_comb begin
		nxt_gate = gate_ff;
		nxt_div_mode = div_mode_ff;
		nxt_edge_sel = edge_sel_ff;
		nxt_init_sel = init_sel_ff;
		nxt_filt_en = filt_en_ff;
		nxt_reload = reload_ff;
		nxt_cnt = cnt_ff;
		nxt_active = active_ff;
		nxt_state = state_ff;
		nxt_irq = 1'b0;
		nxt_out_val = out_val_ff;
		nxt_out_en = out_en_ff;
		nxt_out_mode = out_mode_ff;
		nxt_out_inv = out_inv_ff;
		toggle = 1'b0;

		if (wr_go && hit(wb_adr_in, TED_OFS_GATE) && wb_sel_in[0]) begin
			nxt_gate = wb_dat_in[TED_GATE_BIT];
		end
		if (reg_wr && hit(wb_adr_in, TED_OFS_MODE) && wb_sel_in[0]) begin
			nxt_div_mode = DIV_CAPABLE & wb_dat_in[TED_MODE_DIV_BIT];
			nxt_edge_sel = wb_dat_in[TED_MODE_EDGE_LSB +: 2];
			nxt_init_sel = wb_dat_in[TED_MODE_INIT_BIT];
		end
		// reload held apart from the counter
		if (reg_wr && hit(wb_adr_in, TED_OFS_RELOAD)) begin
			nxt_reload = merge_lanes(reload_ff, wb_dat_in, wb_sel_in);
		end
		if (reg_wr && hit(wb_adr_in, TED_OFS_OUTCTL) && wb_sel_in[0]) begin
			nxt_out_en = wb_dat_in[TED_OUT_EN_BIT];
			nxt_out_mode = wb_dat_in[TED_OUT_MODE_BIT];
			nxt_out_inv = wb_dat_in[TED_OUT_INV_BIT];
			// value written straight while output disabled
			if (!out_en_ff) begin
				nxt_out_val = wb_dat_in[TED_OUT_VAL_BIT];
			end
		end
		if (reg_wr && hit(wb_adr_in, TED_OFS_FILT) && wb_sel_in[0]) begin
			nxt_filt_en = wb_dat_in[TED_FILT_EN_BIT];
		end

		if (stop_wr) begin
			nxt_active = 1'b0;
			nxt_state = TED_ST_IDLE;
		end else if (start_wr) begin
			nxt_active = 1'b1;
			if (div_eff) begin
				nxt_state = TED_ST_WAIT;
			end else begin
				nxt_cnt = reload_ff;
				nxt_state = TED_ST_RUN;
			end
		end else begin
			case (state_ff)
				TED_ST_IDLE: begin
					nxt_state = TED_ST_IDLE;
				end
				TED_ST_WAIT: begin
					if (valid_edge) begin
						nxt_cnt = reload_ff;
						nxt_state = TED_ST_RUN;
						nxt_irq = init_sel_ff;
						toggle = init_sel_ff;
					end
				end
				TED_ST_RUN: begin
					if (valid_edge) begin
						if (cnt_ff == '0) begin
							nxt_cnt = reload_ff;
							nxt_irq = 1'b1;
							toggle = 1'b1;
						end else begin
							nxt_cnt = cnt_ff - 1'b1;
						end
					end
				end
				default: begin
					nxt_state = TED_ST_IDLE;
				end
			endcase
		end

		// event mode toggles too; software clears enable
		if (toggle && out_en_ff && !out_mode_ff) begin
			nxt_out_val = ~out_val_ff;
		end

		// gate off returns everything but the bus and the input sync stages to initial values
		if (!gate_ff) begin
			nxt_div_mode = TED_RST_BIT;
			nxt_edge_sel = TED_RST_EDGE;
			nxt_init_sel = TED_RST_BIT;
			nxt_filt_en = TED_RST_BIT;
			nxt_reload = '0;
			nxt_cnt = '0;
			nxt_active = 1'b0;
			nxt_state = TED_ST_IDLE;
			nxt_irq = 1'b0;
			nxt_out_val = TED_RST_BIT;
			nxt_out_en = TED_RST_BIT;
			nxt_out_mode = TED_RST_BIT;
			nxt_out_inv = TED_RST_BIT;
		end

		// pin follows value only while gated on
		nxt_pin = gate_ff & (out_val_ff ^ out_inv_ff);
		nxt_pin_oe = gate_ff;
	end

	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			gate_ff <= TED_RST_GATE;
			div_mode_ff <= TED_RST_BIT;
			edge_sel_ff <= TED_RST_EDGE;
			init_sel_ff <= TED_RST_BIT;
			filt_en_ff <= TED_RST_BIT;
			reload_ff <= '0;
			cnt_ff <= '0;
			active_ff <= 1'b0;
			state_ff <= TED_ST_IDLE;
			irq_ff <= 1'b0;
			out_val_ff <= TED_RST_BIT;
			out_en_ff <= TED_RST_BIT;
			out_mode_ff <= TED_RST_BIT;
			out_inv_ff <= TED_RST_BIT;
			pin_ff <= 1'b0;
			pin_oe_ff <= 1'b0;
		end else if (ce_in) begin
			gate_ff <= nxt_gate;
			div_mode_ff <= nxt_div_mode;
			edge_sel_ff <= nxt_edge_sel;
			init_sel_ff <= nxt_init_sel;
			filt_en_ff <= nxt_filt_en;
			reload_ff <= nxt_reload;
			cnt_ff <= nxt_cnt;
			active_ff <= nxt_active;
			state_ff <= nxt_state;
			irq_ff <= nxt_irq;
			out_val_ff <= nxt_out_val;
			out_en_ff <= nxt_out_en;
			out_mode_ff <= nxt_out_mode;
			out_inv_ff <= nxt_out_inv;
			pin_ff <= nxt_pin;
			pin_oe_ff <= nxt_pin_oe;
		end
	end

	assign timer_output_pin_out = pin_ff;
	assign timer_output_oe_out = pin_oe_ff;
	assign channel_interrupt_out = irq_ff;

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);

	logic quiet;
	assign quiet = ce_in & gate_ff & ~wr_go;

	sequence s_edge_running;
		quiet && state_ff == TED_ST_RUN && valid_edge;
	endsequence

	property p_start_load;
		ce_in && start_wr && !stop_wr && !div_eff |=>
			cnt_ff == $past(reload_ff) && active_ff
			&& state_ff == TED_ST_RUN;
	endproperty
	a_start_load: assert property (p_start_load)
		else $error("start did not load reload value");

	property p_count_down;
		s_edge_running ##0 cnt_ff != '0 |=>
			cnt_ff == $past(cnt_ff) - 1'b1 && !irq_ff;
	endproperty
	a_count_down: assert property (p_count_down)
		else $error("counter did not step down on edge");

	property p_zero_reload;
		s_edge_running ##0 cnt_ff == '0 |=>
			irq_ff && cnt_ff == $past(reload_ff);
	endproperty
	a_zero_reload: assert property (p_zero_reload)
		else $error("zero did not reload and interrupt");

	property p_irq_cause;
		ce_in && nxt_irq |-> valid_edge && !start_wr && !stop_wr;
	endproperty
	a_irq_cause: assert property (p_irq_cause)
		else $error("interrupt without valid edge");

	property p_stop_hold;
		ce_in && gate_ff && stop_wr |=>
			!active_ff && cnt_ff == $past(cnt_ff)
			&& out_val_ff == $past(out_val_ff);
	endproperty
	a_stop_hold: assert property (p_stop_hold)
		else $error("stop did not halt and hold");

	property p_trig_reads_zero;
		ack_ff && $past(ce_in) && $past(bus_req && !wb_we_in
			&& hit(wb_adr_in, TED_OFS_TRIG)) |-> wb_dat_out == 32'h0000_0000;
	endproperty
	a_trig_reads_zero: assert property (p_trig_reads_zero)
		else $error("trigger register read nonzero");

	property p_gate_reset;
		!gate_ff && $past(!gate_ff) && $past(ce_in) |->
			cnt_ff == '0 && reload_ff == '0 && !active_ff && !out_val_ff;
	endproperty
	a_gate_reset: assert property (p_gate_reset)
		else $error("gate off did not clear channel");

	property p_pin_released;
		!gate_ff && $past(!gate_ff) && $past(ce_in) |->
			!timer_output_oe_out && !timer_output_pin_out;
	endproperty
	a_pin_released: assert property (p_pin_released)
		else $error("pin not released while gated off");

	property p_divider_first;
		quiet && state_ff == TED_ST_WAIT && valid_edge |=>
			state_ff == TED_ST_RUN && cnt_ff == $past(reload_ff)
			&& irq_ff == $past(init_sel_ff);
	endproperty
	a_divider_first: assert property (p_divider_first)
		else $error("divider first edge handled wrongly");

	property p_no_divider;
		!DIV_CAPABLE |-> !div_mode_ff && state_ff != TED_ST_WAIT;
	endproperty
	a_no_divider: assert property (p_no_divider)
		else $error("divider mode on incapable channel");

endmodule // ted_timer

/* File: verilog/ted_pkg.sv */
package ted_pkg;

	////////////////////////////////////////////////////////////////////////
	// register word offsets (byte addresses)
	localparam logic [7:0] TED_OFS_GATE = 8'h00;
	localparam logic [7:0] TED_OFS_MODE = 8'h04;
	localparam logic [7:0] TED_OFS_RELOAD = 8'h08;
	localparam logic [7:0] TED_OFS_COUNT = 8'h0C;
	localparam logic [7:0] TED_OFS_TRIG = 8'h10;
	localparam logic [7:0] TED_OFS_STAT = 8'h14;
	localparam logic [7:0] TED_OFS_OUTCTL = 8'h18;
	localparam logic [7:0] TED_OFS_FILT = 8'h1C;

	////////////////////////////////////////////////////////////////////////
	// field positions
	localparam int TED_GATE_BIT = 0;
	localparam int TED_MODE_DIV_BIT = 0;
	localparam int TED_MODE_EDGE_LSB = 1;
	localparam int TED_MODE_INIT_BIT = 3;
	localparam int TED_TRIG_START_BIT = 0;
	localparam int TED_TRIG_STOP_BIT = 1;
	localparam int TED_STAT_ACTIVE_BIT = 0;
	localparam int TED_OUT_VAL_BIT = 0;
	localparam int TED_OUT_EN_BIT = 1;
	localparam int TED_OUT_MODE_BIT = 2;
	localparam int TED_OUT_INV_BIT = 3;
	localparam int TED_FILT_EN_BIT = 0;

	////////////////////////////////////////////////////////////////////////
	// edge select codes
	localparam logic [1:0] TED_EDGE_FALL = 2'h0;
	localparam logic [1:0] TED_EDGE_RISE = 2'h1;
	localparam logic [1:0] TED_EDGE_BOTH = 2'h2;

	////////////////////////////////////////////////////////////////////////
	// values after reset
	localparam logic TED_RST_GATE = 1'b0;
	localparam logic [1:0] TED_RST_EDGE = 2'h1;
	localparam logic TED_RST_BIT = 1'b0;

	typedef enum logic [1:0] {
		TED_ST_IDLE,
		TED_ST_WAIT,
		TED_ST_RUN
	} ted_state_type;

endpackage

/* File: verilog/ted_edge_det.sv */
`timescale 1ns/100ps
module ted_edge_det import ted_pkg::*; (
	input wire logic sys_clk_in, // operating clock
	input wire logic rst_in, // async reset, active high
	input wire logic ce_in, // clock enable
	input wire logic clear_in, // unit gate off, return all but the two sync stages to initial state
	input wire logic filt_en_in, // noise filter on
	input wire logic [1:0] edge_sel_in, // valid edge select
	input wire logic pin_in, // timer input pin
	output logic edge_out // one cycle valid edge pulse
);

	logic sync1_ff, sync2_ff, samp_ff, level_ff, prev_ff, edge_ff;
	logic nxt_sync1, nxt_sync2, nxt_samp, nxt_level, nxt_prev, nxt_edge;
	logic rise, fall;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		nxt_sync1 = pin_in;
		nxt_sync2 = sync1_ff;
		nxt_samp = sync2_ff;
		// filter needs two equal samples before the level moves
		nxt_level = level_ff;
		if (!filt_en_in || (sync2_ff == samp_ff)) begin
			nxt_level = sync2_ff;
		end
		nxt_prev = level_ff;
		rise = level_ff & ~prev_ff;
		fall = ~level_ff & prev_ff;
		case (edge_sel_in)
			TED_EDGE_FALL: nxt_edge = fall;
			TED_EDGE_RISE: nxt_edge = rise;
			default: nxt_edge = rise | fall;
		endcase
		if (clear_in) begin
			nxt_level = TED_RST_BIT;
			nxt_prev = TED_RST_BIT;
			nxt_samp = TED_RST_BIT;
			nxt_edge = 1'b0;
		end
	end

	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			sync1_ff <= 1'b0;
			sync2_ff <= 1'b0;
			samp_ff <= 1'b0;
			level_ff <= 1'b0;
			prev_ff <= 1'b0;
			edge_ff <= 1'b0;
		end else if (ce_in) begin
			sync1_ff <= nxt_sync1;
			sync2_ff <= nxt_sync2;
			samp_ff <= nxt_samp;
			level_ff <= nxt_level;
			prev_ff <= nxt_prev;
			edge_ff <= nxt_edge;
		end
	end

	assign edge_out = edge_ff;

endmodule // ted_edge_det

/* File: test/ted_edge_src.sv */
`timescale 1ns/100ps
module ted_edge_src #(
	parameter int HALF = 4
)(
	input wire logic sys_clk_in, // operating clock
	input wire logic rst_in, // async reset, active high
	input wire logic go_in, // start a burst of pulses
	input wire logic [7:0] pulses_in, // pulses in the burst
	output logic pin_out, // drives the timer input pin
	output logic busy_out // burst in progress
);
	logic [8:0] left_ff;
	logic [3:0] tick_ff;

	// pulses stay wider than the filter needs; idle level is low
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			left_ff <= 9'h000;
			tick_ff <= 4'h0;
			pin_out <= 1'b0;
		end else if (go_in && left_ff == 9'h000) begin
			left_ff <= {pulses_in, 1'b0};
			tick_ff <= 4'h0;
		end else if (left_ff != 9'h000) begin
			if (tick_ff == 4'(HALF - 1)) begin
				tick_ff <= 4'h0;
				pin_out <= ~pin_out;
				left_ff <= left_ff - 9'h001;
			end else begin
				tick_ff <= tick_ff + 4'h1;
			end
		end
	end

	assign busy_out = (left_ff != 9'h000);
endmodule // ted_edge_src

/* File: test/ted_timer_tb_top.sv */
`timescale 1ns/100ps
module ted_timer_tb_top;
	import ted_pkg::*;
	logic sys_clk, rst, cyc, stb, we, ack, pin_in, pin, oe, irq, go, busy;
	logic [7:0] adr, np;
	logic [31:0] wdat, rdat, q;
	int bad_count, n_tests, irq_n, n0, e;

	ted_timer i_ted_timer (.sys_clk_in(sys_clk), .rst_in(rst),
		.ce_in(1'b1), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we),
		.wb_adr_in(adr), .wb_sel_in(4'hF), .wb_dat_in(wdat),
		.wb_dat_out(rdat), .wb_ack_out(ack), .timer_input_pin_in(pin_in),
		.timer_output_pin_out(pin), .timer_output_oe_out(oe),
		.channel_interrupt_out(irq));
	ted_edge_src i_ted_edge_src (.sys_clk_in(sys_clk), .rst_in(rst),
		.go_in(go), .pulses_in(np), .pin_out(pin_in), .busy_out(busy));

	////////////////////////////////////////////////////////////////////////
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk) if (irq === 1'b1) irq_n++;

	task automatic give_verdict();
		$display("checks %0d, mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic ck(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// hold the request until ack is sampled high, then release;
	// only the watchdog ends a wait that never gets an answer
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge sys_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge sys_clk);
		end while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask

	task automatic rc(input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h00000000);
		ck(q, exp);
	endtask

	// burst of pulses, then time for the edge to reach the counter
	task automatic pulse(input logic [7:0] n);
		int k;
		k = 0;
		@(posedge sys_clk);
		go <= 1'b1;
		np <= n;
		@(posedge sys_clk);
		go <= 1'b0;
		// the source loads its count at the edge above; busy, decoded from it, is high from then on
		@(posedge sys_clk);
		while (busy === 1'b1 && k < 2000) begin
			@(posedge sys_clk);
			k++;
		end
		repeat (8) @(posedge sys_clk);
	endtask

	task automatic ck_pin(input logic exp);
		repeat (2) @(posedge sys_clk);
		ck({31'h0, pin}, {31'h0, exp});
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge sys_clk);
		bad_count++;
		give_verdict();
	end

	initial begin
		rst = 1'b1;
		{cyc, stb, we, go} = 4'h0;
		adr = 8'h00;
		np = 8'h00;
		wdat = 32'h00000000;
		{bad_count, n_tests, irq_n} = 0;
		repeat (4) @(posedge sys_clk);
		rst <= 1'b0;
		wr(TED_OFS_RELOAD, 32'h00000005);
		rc(TED_OFS_RELOAD, 32'h00000000);
		rc(TED_OFS_MODE, 32'h00000002);
		rc(8'h40, 32'h00000000);
		ck({31'h0, oe}, 32'h00000000);
		wr(TED_OFS_GATE, 32'h00000001);
		rc(TED_OFS_GATE, 32'h00000001);
		ck({31'h0, oe}, 32'h00000001);
		// event counting, rising edges, filter on, output disabled
		wr(TED_OFS_FILT, 32'h00000001);
		wr(TED_OFS_MODE, 32'h00000002);
		wr(TED_OFS_RELOAD, 32'h00000002);
		wr(TED_OFS_OUTCTL, 32'h00000000);
		repeat (4) @(posedge sys_clk);
		wr(TED_OFS_TRIG, 32'h00000001);
		rc(TED_OFS_TRIG, 32'h00000000);
		rc(TED_OFS_STAT, 32'h00000001);
		rc(TED_OFS_COUNT, 32'h00000002);
		pulse(8'h02);
		rc(TED_OFS_COUNT, 32'h00000000);
		n0 = irq_n;
		pulse(8'h06);
		ck(32'(irq_n - n0), 32'h00000002);
		rc(TED_OFS_COUNT, 32'h00000000);
		ck({31'h0, pin}, 32'h00000000);
		pulse(8'h02);
		rc(TED_OFS_COUNT, 32'h00000001);
		wr(TED_OFS_RELOAD, 32'h00000004);
		pulse(8'h02);
		rc(TED_OFS_COUNT, 32'h00000004);
		wr(TED_OFS_TRIG, 32'h00000002);
		rc(TED_OFS_STAT, 32'h00000000);
		pulse(8'h02);
		rc(TED_OFS_COUNT, 32'h00000004);
		// every edge select, one pulse each; mode changed only when stopped
		for (e = 0; e < 3; e++) begin
			wr(TED_OFS_MODE, 32'(e * 2));
			wr(TED_OFS_RELOAD, 32'h00000003);
			wr(TED_OFS_TRIG, 32'h00000001);
			pulse(8'h01);
			rc(TED_OFS_COUNT, (e == 2) ? 32'h1 : 32'h2);
			wr(TED_OFS_TRIG, 32'h00000002);
		end
		// divider, rising edges, reload 1, no initial interrupt
		wr(TED_OFS_OUTCTL, 32'h00000001);
		wr(TED_OFS_OUTCTL, 32'h00000003);
		wr(TED_OFS_MODE, 32'h00000003);
		wr(TED_OFS_RELOAD, 32'h00000001);
		wr(TED_OFS_TRIG, 32'h00000001);
		ck_pin(1'b1);
		n0 = irq_n;
		pulse(8'h01);
		ck_pin(1'b1);
		ck(32'(irq_n - n0), 32'h00000000);
		pulse(8'h02);
		ck_pin(1'b0);
		ck(32'(irq_n - n0), 32'h00000001);
		pulse(8'h02);
		ck_pin(1'b1);
		wr(TED_OFS_TRIG, 32'h00000002);
		pulse(8'h02);
		ck_pin(1'b1);
		// initial interrupt selected: first edge toggles
		wr(TED_OFS_MODE, 32'h0000000B);
		wr(TED_OFS_TRIG, 32'h00000001);
		n0 = irq_n;
		pulse(8'h01);
		ck_pin(1'b0);
		ck(32'(irq_n - n0), 32'h00000001);
		wr(TED_OFS_TRIG, 32'h00000002);
		// output disabled: value bit drives the pin; the write that
		// clears the enable still sees it set, so its value is ignored
		wr(TED_OFS_OUTCTL, 32'h00000000);
		ck_pin(1'b0);
		wr(TED_OFS_OUTCTL, 32'h00000001);
		ck_pin(1'b1);
		wr(TED_OFS_OUTCTL, 32'h00000000);
		ck_pin(1'b0);
		wr(TED_OFS_OUTCTL, 32'h00000001);
		ck_pin(1'b1);
		wr(TED_OFS_GATE, 32'h00000000);
		ck_pin(1'b0);
		ck({31'h0, oe}, 32'h00000000);
		rc(TED_OFS_RELOAD, 32'h00000000);
		rc(TED_OFS_OUTCTL, 32'h00000000);
		rc(TED_OFS_MODE, 32'h00000002);
		rc(TED_OFS_FILT, 32'h00000000);
		give_verdict();
	end
endmodule // ted_timer_tb_top
